// ==== core/res_pwm_edge.sv ====
// Resonant-mode PWM edge timer with an AXI4-Lite register slave.
// Assumes one 200 MHz clock, a synchronous reset and a well-behaved bus master.
// Writable register fields are eight bits wide, in the low byte of each bus word.
`timescale 1ns/1ps

module res_pwm_edge
    import res_pwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Register bus
    input wire axil_req_t axil_req_i,
    output axil_rsp_t axil_rsp_o,
    // Power stage drives
    output logic first_pwm_output_o,
    output logic second_pwm_output_o
);

    // Software-visible registers
    logic [REG_W-1:0] switch_freq, next_switch_freq; // Mode select plus reserved bits
    logic [REG_W-1:0] max_cycle_high, next_max_cycle_high; // Limit bits 11:4
    logic [REG_W-1:0] first_output_fall_offset, next_first_output_fall_offset;
    logic [REG_W-1:0] max_cycle_limit_low, next_max_cycle_limit_low;
    logic [REG_W-1:0] second_output_rise_delay, next_second_output_rise_delay;

    // Write channel state
    logic aw_held, next_aw_held; // Write address taken, waiting for data
    logic w_held, next_w_held; // Write data taken, waiting for address
    logic [IDX_W-1:0] wr_idx, next_wr_idx;
    logic [REG_W-1:0] wr_byte, next_wr_byte;
    logic wr_lane, next_wr_lane; // Low byte lane enabled
    logic awready, next_awready;
    logic wready, next_wready;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;

    // Read channel state
    logic arready, next_arready;
    logic rvalid, next_rvalid;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;

    // Cycle timer state
    // The running cycle keeps its own copy of the settings
    edge_cfg_t live, next_live; // Settings owned by the running cycle
    logic [PRE_W-1:0] pre, next_pre; // Step prescaler
    logic [LIMIT_W-1:0] cycle_pos, next_cycle_pos; // Position in 5 ns steps
    logic out_a, next_out_a;
    logic out_b, next_out_b;

    // Combinational helpers
    logic do_write; // Both halves of a write are present
    logic wr_ok; // Write address is mapped and not status
    logic step; // One 5 ns step elapsed
    logic cycle_end; // Last step of the cycle
    logic [LIMIT_W-1:0] last_pos; // Final position of the cycle
    logic [EDGE_W-1:0] midpoint; // Cycle midpoint, unsigned
    logic signed [EDGE_W-1:0] fall_point; // First output fall position
    edge_cfg_t staged; // Settings as software last wrote them

    // Address decode helper for mapped indices
    // Status is mapped for reads only; writes to it are refused
    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        idx_mapped = (idx == IDX_SWITCH_FREQ) || (idx == IDX_MAX_CYCLE_HIGH) ||
            (idx == IDX_FIRST_FALL) || (idx == IDX_MAX_CYCLE_LOW) ||
            (idx == IDX_SECOND_RISE) || (idx == IDX_STATUS);
    endfunction

    // Gather software values into the staged settings
    always_comb begin
        // Mode compare ignores the two plain bits above the select
        staged.resonant = (switch_freq[FREQ_SEL_W-1:0] == FREQ_RESONANT);
        // Eight upper bits joined with the four low bits
        staged.limit = {max_cycle_high, max_cycle_limit_low[LIMIT_LOW_MSB:LIMIT_LOW_LSB]};
        // Offsets pass through untouched; their meaning is applied below
        staged.fall_off = first_output_fall_offset;
        staged.rise_dly = second_output_rise_delay;
    end

    // Write path: address and data taken in either order
    // A new half is refused while bvalid is up, which keeps one write in
    // flight without a separate counter
    // Lane 0 of wstrb gates the register update; other lanes carry no field bits
    always_comb begin
        // Hold everything unless a handshake says otherwise
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wr_idx = wr_idx;
        next_wr_byte = wr_byte;
        next_wr_lane = wr_lane;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_switch_freq = switch_freq;
        next_max_cycle_high = max_cycle_high;
        next_first_output_fall_offset = first_output_fall_offset;
        next_max_cycle_limit_low = max_cycle_limit_low;
        next_second_output_rise_delay = second_output_rise_delay;
        // Capture the address half
        if (axil_req_i.awvalid && awready) begin
            next_aw_held = 1'b1;
            next_wr_idx = axil_req_i.awaddr[ADDR_W-1:WORD_SHIFT];
        end
        // Capture the data half; only the low byte carries fields
        if (axil_req_i.wvalid && wready) begin
            next_w_held = 1'b1;
            next_wr_byte = axil_req_i.wdata[REG_W-1:0];
            next_wr_lane = axil_req_i.wstrb[0];
        end
        // Retire the response
        if (bvalid && axil_req_i.bready) begin
            next_bvalid = 1'b0;
        end
        // Commit once both halves are held and no answer is pending
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (wr_lane) begin
                // Reserved bits are stored as written so software reads them back
                case (wr_idx)
                    IDX_SWITCH_FREQ: next_switch_freq = wr_byte;
                    IDX_MAX_CYCLE_HIGH: next_max_cycle_high = wr_byte;
                    IDX_FIRST_FALL: next_first_output_fall_offset = wr_byte;
                    IDX_MAX_CYCLE_LOW: next_max_cycle_limit_low = wr_byte;
                    IDX_SECOND_RISE: next_second_output_rise_delay = wr_byte;
                    default: ; // Status and unmapped ignore writes
                endcase
            end
        end
        // Ready only while the half is still free and nothing waits
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready = ~next_w_held & ~next_bvalid;
    end

    // Write decode terms
    // Commit waits for a free response slot so bresp is never overwritten
    always_comb begin
        do_write = aw_held && w_held && !bvalid;
        wr_ok = idx_mapped(wr_idx) && (wr_idx != IDX_STATUS);
    end

    // Read path: one read in flight, answered the cycle after it is taken
    always_comb begin
        logic [IDX_W-1:0] rd_idx;
        // Decoded straight off the bus; only used on the taking edge
        rd_idx = axil_req_i.araddr[ADDR_W-1:WORD_SHIFT];
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && axil_req_i.rready) begin
            next_rvalid = 1'b0;
        end
        if (axil_req_i.arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            next_rdata = '0; // Upper bits and unmapped words read zero
            case (rd_idx)
                IDX_SWITCH_FREQ: next_rdata[REG_W-1:0] = switch_freq;
                IDX_MAX_CYCLE_HIGH: next_rdata[REG_W-1:0] = max_cycle_high;
                IDX_FIRST_FALL: next_rdata[REG_W-1:0] = first_output_fall_offset;
                IDX_MAX_CYCLE_LOW: next_rdata[REG_W-1:0] = max_cycle_limit_low;
                IDX_SECOND_RISE: next_rdata[REG_W-1:0] = second_output_rise_delay;
                IDX_STATUS: begin
                    // Live cycle position and mode, for software to watch
                    // These show the running cycle, not the staged settings
                    next_rdata[LIMIT_W-1:0] = cycle_pos;
                    next_rdata[STAT_ACTIVE_BIT] = live.resonant;
                end
                default: ;
            endcase
        end
        // Ready follows rvalid so a second read cannot slip in
        next_arready = ~next_rvalid;
    end

    // Cycle geometry from the settings in force
    always_comb begin
        // A zero limit would never end a cycle, so it behaves as one step
        last_pos = (live.limit == '0) ? '0 : live.limit - 1'b1;
        step = (pre == '0);
        cycle_end = step && (cycle_pos >= last_pos);
        // Midpoint rounds down for odd limits
        midpoint = EDGE_W'(live.limit >> 1);
        // Two spare bits keep the signed sum clear of overflow at both ends
        // Sign extension makes codes above 0x7F lead the midpoint
        fall_point = $signed(midpoint) +
            $signed({{(EDGE_W-REG_W){live.fall_off[REG_W-1]}}, live.fall_off});
    end

    // Cycle timer and output shaping
    always_comb begin
        next_live = live;
        // Prescaler stays at zero while a step equals one clock; it is kept
        // so a faster core clock only changes the package
        next_pre = (pre >= PRE_W'(STEP_CYC - 1)) ? '0 : pre + 1'b1;
        next_cycle_pos = cycle_pos;
        // Position advances once per step
        if (step) begin
            next_cycle_pos = cycle_pos + 1'b1;
        end
        if (cycle_end) begin
            // Settings and mode change only here, never mid-pulse
            next_cycle_pos = '0;
            next_live = staged;
        end
        if (!live.resonant) begin
            // Outside resonant mode the edges are not driven
            next_out_a = 1'b0;
            next_out_b = 1'b0;
        end else begin
            // First output high from cycle start until its fall point
            // A fall point at or below zero holds it low all cycle,
            // one at or past the limit holds it high all cycle
            next_out_a = $signed({2'b00, cycle_pos}) < fall_point;
            // Second output rises after its delay, ends with the cycle
            // A delay at or past the limit keeps it low all cycle
            next_out_b = cycle_pos >= LIMIT_W'(live.rise_dly);
        end
    end

    // Register every next value
    always_ff @(posedge clk_i) begin
        // Synchronous reset clears every setting, so the mode starts off
        // and both drives start low
        if (srst_i) begin
            switch_freq <= RST_REG;
            max_cycle_high <= RST_REG;
            first_output_fall_offset <= RST_REG;
            max_cycle_limit_low <= RST_REG;
            second_output_rise_delay <= RST_REG;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_idx <= '0;
            wr_byte <= '0;
            wr_lane <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
            live <= '0;
            pre <= '0;
            cycle_pos <= '0;
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else begin
            // Normal running: every register takes its next value each clock
            switch_freq <= next_switch_freq;
            max_cycle_high <= next_max_cycle_high;
            first_output_fall_offset <= next_first_output_fall_offset;
            max_cycle_limit_low <= next_max_cycle_limit_low;
            second_output_rise_delay <= next_second_output_rise_delay;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wr_idx <= next_wr_idx;
            wr_byte <= next_wr_byte;
            wr_lane <= next_wr_lane;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            live <= next_live;
            pre <= next_pre;
            cycle_pos <= next_cycle_pos;
            out_a <= next_out_a;
            out_b <= next_out_b;
        end
    end

    // Outputs straight from flip-flops
    // Bus answers and drives are copies of flops, no logic in between
    always_comb begin
        axil_rsp_o.awready = awready;
        axil_rsp_o.wready = wready;
        axil_rsp_o.bresp = bresp;
        axil_rsp_o.bvalid = bvalid;
        axil_rsp_o.arready = arready;
        axil_rsp_o.rdata = rdata;
        axil_rsp_o.rresp = rresp;
        axil_rsp_o.rvalid = rvalid;
        first_pwm_output_o = out_a;
        second_pwm_output_o = out_b;
    end

endmodule

// ==== core/res_pwm_pkg.sv ====
// Constants, register map and bus carriers for the resonant PWM edge timer.
// Assumes a 200 MHz core clock and an AXI4-Lite master with 32-bit data.
package res_pwm_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = ADDR_W - 2;
    localparam int WORD_SHIFT = 2;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SWITCH_FREQ = 10'h040;
    localparam logic [IDX_W-1:0] IDX_MAX_CYCLE_HIGH = 10'h042;
    localparam logic [IDX_W-1:0] IDX_FIRST_FALL = 10'h043;
    localparam logic [IDX_W-1:0] IDX_MAX_CYCLE_LOW = 10'h044;
    localparam logic [IDX_W-1:0] IDX_SECOND_RISE = 10'h045;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h050;

    // Field layout
    localparam int FREQ_SEL_W = 6;
    localparam logic [FREQ_SEL_W-1:0] FREQ_RESONANT = 6'h3f;
    localparam int LIMIT_W = 12;
    localparam int LIMIT_LOW_MSB = 7;
    localparam int LIMIT_LOW_LSB = 4;
    localparam int STAT_ACTIVE_BIT = 16;
    localparam int EDGE_W = LIMIT_W + 2;

    // Reset values
    localparam logic [REG_W-1:0] RST_REG = 8'h00;

    // Response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing: one field step is 5 ns, the clock period is 5 ns
    localparam int STEP_NS = 5;
    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_W = 4;

    // Bus request from the master
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W/8-1:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    // Bus response to the master
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;

    // Edge settings as used by the running cycle
    typedef struct packed {
        logic resonant;
        logic [LIMIT_W-1:0] limit;
        logic [REG_W-1:0] fall_off;
        logic [REG_W-1:0] rise_dly;
    } edge_cfg_t;

endpackage

// ==== tb/res_pwm_stage.sv ====
// Power stage model: integrates conduction time of both switches.
// Assumes outputs are sampled on the core clock, one count per 5 ns.
`timescale 1ns/1ps
module res_pwm_stage (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Switch drives
    input wire logic first_i,
    input wire logic second_i,
    // Conduction counters
    output logic [31:0] first_cnt_o,
    output logic [31:0] second_cnt_o
);
    // Free running, so the bench takes differences and never races a clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            first_cnt_o <= 32'h0000_0000;
            second_cnt_o <= 32'h0000_0000;
        end else begin
            first_cnt_o <= first_cnt_o + {31'h0, first_i};
            second_cnt_o <= second_cnt_o + {31'h0, second_i};
        end
    end
endmodule

// ==== tb/res_pwm_edge_props.sv ====
// Bus timing and output properties of the resonant PWM edge timer.
// Sees only the top module ports; attached by bind below.
`timescale 1ns/1ps
module res_pwm_edge_props
    import res_pwm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Watched ports
    input wire axil_req_t axil_req_i,
    input wire axil_rsp_t axil_rsp_o,
    input wire logic first_pwm_output_o,
    input wire logic second_pwm_output_o
);
    logic wr_take; // Address and data taken at one edge
    logic ever_res; // Resonant mode requested since reset
    logic next_ever_res;
    assign wr_take = axil_req_i.awvalid && axil_rsp_o.awready
        && axil_req_i.wvalid && axil_rsp_o.wready;
    // Sticky: outputs may lag a mode request by a whole cycle
    always_comb begin
        next_ever_res = ever_res;
        if (wr_take && axil_req_i.awaddr[ADDR_W-1:WORD_SHIFT] == IDX_SWITCH_FREQ
            && axil_req_i.wdata[FREQ_SEL_W-1:0] == FREQ_RESONANT) begin
            next_ever_res = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        ever_res <= srst_i ? 1'b0 : next_ever_res;
    end
    sequence s_both_taken;
        wr_take;
    endsequence
    sequence s_commit;
        !axil_rsp_o.bvalid ##1 axil_rsp_o.bvalid;
    endsequence
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_reset_quiet: assert property (disable iff (1'b0) srst_i |=> !first_pwm_output_o
        && !second_pwm_output_o && !axil_rsp_o.bvalid && !axil_rsp_o.rvalid)
        else $error("outputs active after reset");
    a_idle_low: assert property (!ever_res |-> !first_pwm_output_o && !second_pwm_output_o)
        else $error("output driven outside resonant mode");
    a_write_lat: assert property (s_both_taken |=> s_commit)
        else $error("write response timing wrong");
    a_write_err: assert property (s_both_taken
        and axil_req_i.awaddr[ADDR_W-1:WORD_SHIFT] == 10'h3ff
        |=> s_commit ##0 axil_rsp_o.bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_read_lat: assert property (axil_req_i.arvalid && axil_rsp_o.arready |=> axil_rsp_o.rvalid)
        else $error("read data late");
    a_bresp_hold: assert property (axil_rsp_o.bvalid && !axil_req_i.bready
        |=> axil_rsp_o.bvalid && $stable(axil_rsp_o.bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (axil_rsp_o.rvalid && !axil_req_i.rready
        |=> axil_rsp_o.rvalid && $stable(axil_rsp_o.rdata))
        else $error("read data dropped");
    a_ar_block: assert property (axil_rsp_o.rvalid |-> !axil_rsp_o.arready)
        else $error("read taken while data pending");
endmodule
bind res_pwm_edge res_pwm_edge_props res_pwm_edge_props_inst (.clk_i(clk_i),
    .srst_i(srst_i), .axil_req_i(axil_req_i), .axil_rsp_o(axil_rsp_o),
    .first_pwm_output_o(first_pwm_output_o), .second_pwm_output_o(second_pwm_output_o));

// ==== tb/tb.sv ====
// Self-checking bench: register access and measured edge timing.
// Assumes a 200 MHz clock; one conduction count per clock equals 5 ns.
`timescale 1ns/1ps
module tb;
    import res_pwm_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    axil_req_t req = '0; // Bus master drive
    axil_rsp_t rsp;
    logic first_o, second_o;
    logic [31:0] first_cnt, second_cnt; // Stage conduction counts
    int error_cnt = 0;
    int cmp_count = 0;
    res_pwm_edge res_pwm_edge_inst (.clk_i(clk_i), .srst_i(srst_i), .axil_req_i(req),
        .axil_rsp_o(rsp), .first_pwm_output_o(first_o), .second_pwm_output_o(second_o));
    res_pwm_stage res_pwm_stage_inst (.clk_i(clk_i), .srst_i(srst_i), .first_i(first_o),
        .second_i(second_o), .first_cnt_o(first_cnt), .second_cnt_o(second_cnt));
    // 5 ns clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One write; an idle edge first so bready never toggles twice in a step
    task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [7:0] d,
        input logic [1:0] er);
        @(posedge clk_i);
        req.awaddr <= {idx, 2'b00};
        req.awvalid <= 1'b1;
        req.wdata <= {24'h00_0000, d};
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
    endtask
    // One read; data and response handed back as sampled with rvalid
    task automatic rd_raw(input logic [IDX_W-1:0] idx, output logic [31:0] got,
        output logic [1:0] rs);
        @(posedge clk_i);
        req.araddr <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        forever begin
            @(posedge clk_i);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        req.rready <= 1'b0;
        got = rsp.rdata;
        rs = rsp.rresp;
    endtask
    task automatic axi_read(input logic [IDX_W-1:0] idx, input logic [31:0] e,
        input logic [1:0] er);
        logic [31:0] got;
        logic [1:0] rs;
        rd_raw(idx, got, rs);
        chk("rdata", e, got);
        chk("rresp", {30'h0, er}, {30'h0, rs});
    endtask
    // High time of both drives over len clocks
    task automatic measure(input int len, input logic [31:0] ef, input logic [31:0] es);
        logic [31:0] f0, s0;
        @(posedge clk_i);
        #1;
        f0 = first_cnt;
        s0 = second_cnt;
        repeat (len) @(posedge clk_i);
        #1;
        chk("first_high", ef, first_cnt - f0);
        chk("second_high", es, second_cnt - s0);
    endtask
    // Reset values, read back, refused places
    task automatic t_regs();
        logic [IDX_W-1:0] idx_tab [5];
        idx_tab = '{IDX_SWITCH_FREQ, IDX_MAX_CYCLE_HIGH, IDX_FIRST_FALL, IDX_MAX_CYCLE_LOW,
            IDX_SECOND_RISE};
        foreach (idx_tab[i]) axi_read(idx_tab[i], 32'h0000_0000, RESP_OKAY);
        for (int i = 2; i < 5; i++) begin
            axi_write(idx_tab[i], 8'ha5, RESP_OKAY);
            axi_read(idx_tab[i], 32'h0000_00a5, RESP_OKAY);
        end
        axi_read(10'h3ff, 32'h0000_0000, RESP_SLVERR);
        axi_write(10'h3ff, 8'h3f, RESP_SLVERR);
        axi_write(IDX_STATUS, 8'hff, RESP_SLVERR);
    endtask
    // Mode one bit short of all ones must keep both drives low
    task automatic t_idle();
        axi_write(IDX_MAX_CYCLE_HIGH, 8'h01, RESP_OKAY);
        axi_write(IDX_SWITCH_FREQ, 8'h3e, RESP_OKAY);
        repeat (40) @(posedge clk_i);
        measure(40, 32'h0, 32'h0);
    endtask
    // Table of limits and offsets at field boundaries
    task automatic t_edges();
        logic [7:0] tab [7][4];
        int lim, fp, prev;
        tab = '{'{8'h19, 8'h0a, 8'h00, 8'h00}, '{8'h19, 8'h0a, 8'h01, 8'h01},
            '{8'h19, 8'h0a, 8'h7f, 8'hff}, '{8'h19, 8'h0a, 8'h80, 8'h80},
            '{8'h19, 8'h0a, 8'hff, 8'h10}, '{8'h01, 8'hfa, 8'h05, 8'h10},
            '{8'h00, 8'h3a, 8'h00, 8'h00}};
        axi_write(IDX_SWITCH_FREQ, 8'h3f, RESP_OKAY);
        prev = 4095; // Longest cycle that may still run from earlier tests
        foreach (tab[i]) begin
            axi_write(IDX_MAX_CYCLE_HIGH, tab[i][0], RESP_OKAY);
            axi_write(IDX_MAX_CYCLE_LOW, tab[i][1], RESP_OKAY);
            axi_write(IDX_FIRST_FALL, tab[i][2], RESP_OKAY);
            axi_write(IDX_SECOND_RISE, tab[i][3], RESP_OKAY);
            // Reserved low nibble of the limit low byte is ignored
            lim = tab[i][0] * 16 + tab[i][1][7:4];
            fp = lim / 2 + (tab[i][2] < 128 ? tab[i][2] : tab[i][2] - 256);
            fp = fp < 0 ? 0 : (fp > lim ? lim : fp);
            // Let the old cycle, a half-written one and the wrap pass
            repeat (prev + tab[i][0] * 16 + 15 + 8) @(posedge clk_i);
            measure(lim, fp, tab[i][3] < lim ? lim - tab[i][3] : 0);
            prev = lim;
        end
    endtask
    // Mode change written early in a long cycle must wait for its end
    task automatic t_boundary();
        logic [31:0] got;
        logic [1:0] rs;
        int q;
        axi_write(IDX_MAX_CYCLE_HIGH, 8'h19, RESP_OKAY);
        axi_write(IDX_MAX_CYCLE_LOW, 8'h00, RESP_OKAY);
        repeat (900) @(posedge clk_i);
        rd_raw(IDX_STATUS, got, rs);
        chk("status_rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
        chk("status_mode", 32'h1, {31'h0, got[STAT_ACTIVE_BIT]});
        chk("status_pos", 32'h1, {31'h0, (got[LIMIT_W-1:0] < 12'd400)});
        q = got[LIMIT_W-1:0];
        // Step to just after a cycle start so the write lands mid-cycle
        repeat ((400 - q) % 400) @(posedge clk_i);
        axi_write(IDX_SWITCH_FREQ, 8'h3e, RESP_OKAY);
        rd_raw(IDX_STATUS, got, rs);
        chk("mode_held", 32'h1, {31'h0, got[STAT_ACTIVE_BIT]});
        repeat (410) @(posedge clk_i);
        rd_raw(IDX_STATUS, got, rs);
        chk("mode_off", 32'h0, {31'h0, got[STAT_ACTIVE_BIT]});
        measure(400, 32'h0, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog well above the roughly 13k cycles the tests take
    initial begin
        #(40000 * 5);
        error_cnt++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_idle();
        t_edges();
        t_boundary();
        tally_and_finish();
    end
endmodule
